/* File: rtl/pmto_map.svh */
// register offsets, field positions, reset values and timing for the pm timeout block
`ifndef PMTO_MAP_SVH
`define PMTO_MAP_SVH
// byte addresses, one aligned word each
`define PMTO_OFF_CEB      8'h00
`define PMTO_OFF_PERIOD   8'h04
`define PMTO_OFF_TRIG     8'h08
`define PMTO_OFF_TSTAT    8'h0c
`define PMTO_OFF_BASE     8'h10
`define PMTO_OFF_SUPPORT  8'h30
`define PMTO_WORD_STEP    8'h04
// reset values
`define PMTO_CEB_RST      8'h0e
`define PMTO_ZERO8        8'h00
// writable bits
`define PMTO_CEB_WMASK    8'h0f
`define PMTO_TRIG_WMASK   8'h0f
// read-only low bits of the base-address low bytes
`define PMTO_RO_EVT       8'h03
`define PMTO_RO_TMR       8'h03
`define PMTO_RO_CTL       8'h01
`define PMTO_RO_GP        8'h0f
// field positions
`define PMTO_CEB_TMR_CLK  0
`define PMTO_CEB_UNIT_LSB 1
`define PMTO_CEB_BUSY_LSB 6
`define PMTO_SUP_SLP_STS  0
`define PMTO_SUP_SLP_EN   1
`define PMTO_SUP_GL_STS   2
`define PMTO_SUP_GL_EN    3
`define PMTO_SUP_GL_REL   4
`define PMTO_SUP_SMI_STS  5
`define PMTO_SUP_SMI_EN   6
`define PMTO_SUP_PM1_MASK 7
// one-minute tick
`define PMTO_MINUTE_S     64'd60
`define PMTO_CLK_HZ       64'd200000000
`endif

/* File: rtl/pmto_pkg.sv */
// types shared by the pm timeout block and its users
package pmto_pkg;
    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } pmto_apb_s;
    // relocatable acpi group bases
    typedef struct packed {
        logic [15:0] event_base;
        logic [15:0] timer_base;
        logic [15:0] control_base;
        logic [15:0] gp_status_base;
    } pmto_bases_s;
    // qualifiers for the acpi fixed register logic
    typedef struct packed {
        logic timer_regs_en;
        logic pm1_other_mask;
        logic glock_set;
    } pmto_acpi_s;
endpackage

/* File: rtl/pmto_top.sv */
// power-management clock enables, minute timeout timer and acpi support registers
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "pmto_map.svh"

module pmto_top #(
    parameter logic [35:0] MINUTE_CYCLES = 36'(`PMTO_MINUTE_S * `PMTO_CLK_HZ)
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire pmto_pkg::pmto_apb_s   apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  soft_reset,
    input  wire logic                  pm_activate,
    input  wire logic [2:0]            unit_cfg_clk,
    output logic [2:0]                 unit_clk_en,
    input  wire logic [1:0]            serial_busy,
    input  wire logic [3:0]            trigger_irq,
    input  wire logic                  sleep_en_write,
    input  wire logic                  glock_release_write,
    input  wire logic                  smi_cmd_write,
    output logic                       pm_active,
    output logic                       expiry_output_n,
    output logic                       irq_req,
    output pmto_pkg::pmto_bases_s      bases,
    output pmto_pkg::pmto_acpi_s       acpi_ctl
);
    import pmto_pkg::*;

    logic [7:0]  clock_enable_busy_reg;
    logic [7:0]  timeout_period_reg;
    logic [7:0]  timeout_trigger_reg;
    logic [7:0]  timeout_status_reg;
    logic [7:0]  acpi_support_reg;
    logic [7:0]  base_reg [8];
    logic [7:0]  count_reg;
    logic        running_reg;
    logic [35:0] presc_reg;
    logic        glock_set_reg;
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic        tick;
    logic        trig_hit;
    logic        wd_clear;
    logic [7:0]  wdata;
    logic [7:0]  rd_next;
    logic [7:0]  base_hit;

    // zero-wait slave: every access phase completes at once
    assign pready   = 1'b1;
    assign wdata    = apb_req.pwdata[7:0];
    assign wr_en    = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_req.pstrb[0];
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign mapped   = (apb_req.paddr == `PMTO_OFF_CEB) | (apb_req.paddr == `PMTO_OFF_PERIOD)
                    | (apb_req.paddr == `PMTO_OFF_TRIG) | (apb_req.paddr == `PMTO_OFF_TSTAT)
                    | (apb_req.paddr == `PMTO_OFF_SUPPORT) | (|base_hit);
    // unmapped addresses answer with an error, writes there are dropped
    assign pslverr  = apb_req.psel & apb_req.penable & ~mapped;

    // base-address bytes: evt lo/hi, tmr lo/hi, ctl lo/hi, gp lo/hi
    function automatic logic [7:0] base_ro_mask(input int idx);
        case (idx)
            0:       base_ro_mask = `PMTO_RO_EVT;
            2:       base_ro_mask = `PMTO_RO_TMR;
            4:       base_ro_mask = `PMTO_RO_CTL;
            6:       base_ro_mask = `PMTO_RO_GP;
            default: base_ro_mask = `PMTO_ZERO8;
        endcase
    endfunction

    for (genvar i = 0; i < 8; i++) begin : g_base
        localparam logic [7:0] OFF = `PMTO_OFF_BASE + 8'(i) * `PMTO_WORD_STEP;
        assign base_hit[i] = (apb_req.paddr == OFF);
        // read-only low bits stay zero whatever software writes
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                base_reg[i] <= `PMTO_ZERO8;
            end else if (wr_en && base_hit[i]) begin
                base_reg[i] <= wdata & ~base_ro_mask(i);
            end
        end
    end

    assign bases.event_base     = {base_reg[1], base_reg[0]};
    assign bases.timer_base     = {base_reg[3], base_reg[2]};
    assign bases.control_base   = {base_reg[5], base_reg[4]};
    assign bases.gp_status_base = {base_reg[7], base_reg[6]};

    // clock enables; busy bits are live inputs, never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_enable_busy_reg <= `PMTO_CEB_RST;
        end else if (wr_en && apb_req.paddr == `PMTO_OFF_CEB) begin
            clock_enable_busy_reg <= wdata & `PMTO_CEB_WMASK;
        end
    end

    // unit clock gates: both our bit and the unit's own config bit
    for (genvar u = 0; u < 3; u++) begin : g_unit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                unit_clk_en[u] <= 1'b0;
            end else begin
                unit_clk_en[u] <= clock_enable_busy_reg[`PMTO_CEB_UNIT_LSB + u] & unit_cfg_clk[u];
            end
        end
    end

    // pm logical device active flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_active <= 1'b0;
        end else if (soft_reset) begin
            pm_active <= 1'b0;
        end else if (pm_activate) begin
            pm_active <= 1'b1;
        end
    end

    // hard reset is the async path; these are the synchronous clears
    assign wd_clear = pm_activate | soft_reset;

    // programmed period, never the running count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_period_reg <= `PMTO_ZERO8;
        end else if (wd_clear) begin
            timeout_period_reg <= `PMTO_ZERO8;
        end else if (wr_en && apb_req.paddr == `PMTO_OFF_PERIOD) begin
            timeout_period_reg <= wdata;
        end
    end

    // trigger enables for kbd, mouse, serial a, serial b
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_trigger_reg <= `PMTO_ZERO8;
        end else if (pm_activate) begin
            timeout_trigger_reg <= `PMTO_ZERO8;
        end else if (wr_en && apb_req.paddr == `PMTO_OFF_TRIG) begin
            timeout_trigger_reg <= wdata & `PMTO_TRIG_WMASK;
        end
    end

    // inputs arrive already at their active level, so polarity does not matter
    assign trig_hit = |(trigger_irq & timeout_trigger_reg[3:0]);
    assign tick     = running_reg && (presc_reg == MINUTE_CYCLES - 36'd1);

    // minute prescaler restarts with each load so a period is whole minutes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= '0;
        end else if (!running_reg || trig_hit || tick || wd_clear
                     || (wr_en && apb_req.paddr == `PMTO_OFF_PERIOD)) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 36'd1;
        end
    end

    // countdown: clear beats software write beats trigger beats tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg       <= `PMTO_ZERO8;
            running_reg     <= 1'b0;
            expiry_output_n <= 1'b1;
        end else if (wd_clear) begin
            count_reg       <= `PMTO_ZERO8;
            running_reg     <= 1'b0;
            expiry_output_n <= 1'b1;
        end else if (wr_en && apb_req.paddr == `PMTO_OFF_PERIOD) begin
            count_reg       <= wdata;
            running_reg     <= (wdata != `PMTO_ZERO8);
            expiry_output_n <= 1'b1;
        end else if (running_reg && trig_hit) begin
            count_reg <= timeout_period_reg;
        end else if (tick) begin
            count_reg <= count_reg - 8'd1;
            if (count_reg == 8'd1) begin
                running_reg     <= 1'b0;
                expiry_output_n <= 1'b0;
            end
        end
    end

    // status mirrors the expiry level even when the pin serves as gpio
    assign timeout_status_reg = {7'h00, expiry_output_n};

    // acpi support: sticky bits where the hardware set wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acpi_support_reg <= `PMTO_ZERO8;
        end else begin
            if (wr_en && apb_req.paddr == `PMTO_OFF_SUPPORT) begin
                acpi_support_reg[`PMTO_SUP_SLP_EN]   <= wdata[`PMTO_SUP_SLP_EN];
                acpi_support_reg[`PMTO_SUP_GL_EN]    <= wdata[`PMTO_SUP_GL_EN];
                acpi_support_reg[`PMTO_SUP_SMI_EN]   <= wdata[`PMTO_SUP_SMI_EN];
                acpi_support_reg[`PMTO_SUP_PM1_MASK] <= wdata[`PMTO_SUP_PM1_MASK];
                if (wdata[`PMTO_SUP_SLP_STS]) begin
                    acpi_support_reg[`PMTO_SUP_SLP_STS] <= 1'b0;
                end
                if (wdata[`PMTO_SUP_GL_STS]) begin
                    acpi_support_reg[`PMTO_SUP_GL_STS] <= 1'b0;
                end
                if (wdata[`PMTO_SUP_SMI_STS]) begin
                    acpi_support_reg[`PMTO_SUP_SMI_STS] <= 1'b0;
                end
            end
            if (sleep_en_write) begin
                acpi_support_reg[`PMTO_SUP_SLP_STS] <= 1'b1;
            end
            if (glock_release_write) begin
                acpi_support_reg[`PMTO_SUP_GL_STS] <= 1'b1;
            end
            if (smi_cmd_write) begin
                acpi_support_reg[`PMTO_SUP_SMI_STS] <= 1'b1;
            end
        end
    end

    // interrupt request from each enabled sticky status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= (acpi_support_reg[`PMTO_SUP_SLP_STS] & acpi_support_reg[`PMTO_SUP_SLP_EN])
                     | (acpi_support_reg[`PMTO_SUP_GL_STS] & acpi_support_reg[`PMTO_SUP_GL_EN])
                     | (acpi_support_reg[`PMTO_SUP_SMI_STS] & acpi_support_reg[`PMTO_SUP_SMI_EN]);
        end
    end

    // lock release bit is write-only: one-cycle pulse to the pm1 status logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glock_set_reg <= 1'b0;
        end else begin
            glock_set_reg <= wr_en && apb_req.paddr == `PMTO_OFF_SUPPORT
                             && wdata[`PMTO_SUP_GL_REL];
        end
    end

    assign acpi_ctl.timer_regs_en  = clock_enable_busy_reg[`PMTO_CEB_TMR_CLK];
    assign acpi_ctl.pm1_other_mask = acpi_support_reg[`PMTO_SUP_PM1_MASK];
    assign acpi_ctl.glock_set      = glock_set_reg;

    // read mux; the snapshot is taken in the setup cycle
    always_comb begin
        rd_next = `PMTO_ZERO8;
        case (apb_req.paddr)
            `PMTO_OFF_CEB:     rd_next = {serial_busy[0], serial_busy[1],
                                          clock_enable_busy_reg[5:0]};
            `PMTO_OFF_PERIOD:  rd_next = timeout_period_reg;
            `PMTO_OFF_TRIG:    rd_next = timeout_trigger_reg;
            `PMTO_OFF_TSTAT:   rd_next = timeout_status_reg;
            `PMTO_OFF_SUPPORT: rd_next = acpi_support_reg & ~(8'h01 << `PMTO_SUP_GL_REL);
            default: begin
                for (int k = 0; k < 8; k++) begin
                    if (base_hit[k]) begin
                        rd_next = base_reg[k];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= {24'h000000, rd_next};
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire period_wr = wr_en && apb_req.paddr == `PMTO_OFF_PERIOD;
    wire sup_wr    = wr_en && apb_req.paddr == `PMTO_OFF_SUPPORT;
    wire [2:0] irq_armed = {acpi_support_reg[`PMTO_SUP_SMI_STS] & acpi_support_reg[`PMTO_SUP_SMI_EN],
                            acpi_support_reg[`PMTO_SUP_GL_STS] & acpi_support_reg[`PMTO_SUP_GL_EN],
                            acpi_support_reg[`PMTO_SUP_SLP_STS] & acpi_support_reg[`PMTO_SUP_SLP_EN]};

    sequence s_last_minute;
        tick && count_reg == 8'd1 && !trig_hit && !period_wr && !wd_clear;
    endsequence

    sequence s_sleep_armed;
        acpi_support_reg[`PMTO_SUP_SLP_STS] && acpi_support_reg[`PMTO_SUP_SLP_EN];
    endsequence

    chk_zero_write_idle: assert property (period_wr && wdata == 8'h00 && !wd_clear
        |=> expiry_output_n && !running_reg && count_reg == 8'h00)
        else $error("zero period write left timer running");
    chk_expiry_assert: assert property (s_last_minute |=> !expiry_output_n && count_reg == 8'h00)
        else $error("countdown end did not drive expiry low");
    chk_nonzero_start: assert property (period_wr && wdata != 8'h00 && !wd_clear
        |=> expiry_output_n && running_reg && count_reg == $past(wdata))
        else $error("non-zero write did not start countdown");
    chk_activate_clear: assert property (pm_activate
        |=> timeout_period_reg == 8'h00 && timeout_trigger_reg == 8'h00 && expiry_output_n)
        else $error("activation did not clear timeout state");
    chk_soft_reset_pm: assert property (soft_reset |=> !pm_active && !running_reg)
        else $error("software reset left pm device or timer active");
    chk_trigger_reload: assert property (running_reg && trig_hit && !period_wr && !wd_clear
        |=> count_reg == $past(timeout_period_reg))
        else $error("enabled trigger did not reload countdown");
    chk_unit_clock_gate: assert property ($rose(unit_clk_en[0])
        |-> $past(clock_enable_busy_reg[`PMTO_CEB_UNIT_LSB] && unit_cfg_clk[0]))
        else $error("unit clock enabled without both bits");
    chk_status_read: assert property (rd_setup && apb_req.paddr == `PMTO_OFF_TSTAT
        |=> prdata[7:0] == {7'h00, $past(expiry_output_n)})
        else $error("status read does not mirror expiry");
    chk_sleep_sticky: assert property (sleep_en_write
        || (acpi_support_reg[`PMTO_SUP_SLP_STS] && !(sup_wr && wdata[`PMTO_SUP_SLP_STS]))
        |=> acpi_support_reg[`PMTO_SUP_SLP_STS])
        else $error("sleep status not held after set");
    chk_sleep_irq: assert property (s_sleep_armed |=> irq_req)
        else $error("armed sleep status did not raise request");
    chk_glock_pulse: assert property (wr_en && apb_req.paddr == `PMTO_OFF_SUPPORT
        && !wdata[`PMTO_SUP_GL_REL] |=> !acpi_ctl.glock_set)
        else $error("lock release pulse without a one written");
    chk_period_read: assert property (rd_setup && apb_req.paddr == `PMTO_OFF_PERIOD
        |=> prdata[7:0] == $past(timeout_period_reg))
        else $error("period read did not return programmed value");

    // held and refused states of the countdown and of the unit clock
    chk_expiry_hold: assert property (!expiry_output_n && !period_wr && !wd_clear
        |=> !expiry_output_n)
        else $error("expiry released without a clear or period write");
    chk_idle_count_hold: assert property (!running_reg && !period_wr && !wd_clear
        |=> !running_reg && count_reg == $past(count_reg))
        else $error("idle countdown moved without a period write");
    chk_unit_clock_off: assert property (
        !(clock_enable_busy_reg[`PMTO_CEB_UNIT_LSB + 2] && unit_cfg_clk[2]) |=> !unit_clk_en[2])
        else $error("unit clock enabled with a gate bit clear");

    // register side: read-only bits, busy flags, sticky bits and request
    chk_base_ro_bits: assert property (bases.event_base[1:0] == 2'h0 && bases.timer_base[1:0] == 2'h0
        && bases.control_base[0] == 1'h0 && bases.gp_status_base[3:0] == 4'h0)
        else $error("read-only base bits are not zero");
    chk_busy_read: assert property (rd_setup && apb_req.paddr == `PMTO_OFF_CEB
        |=> prdata[7:6] == {$past(serial_busy[0]), $past(serial_busy[1])})
        else $error("busy flags not returned in bits 7 and 6");
    chk_sleep_clear: assert property (sup_wr && wdata[`PMTO_SUP_SLP_STS] && !sleep_en_write
        |=> !acpi_support_reg[`PMTO_SUP_SLP_STS])
        else $error("write one did not clear sleep status");
    chk_glock_set: assert property (sup_wr && wdata[`PMTO_SUP_GL_REL] |=> acpi_ctl.glock_set)
        else $error("lock release write gave no set pulse");
    chk_glock_irq: assert property (irq_armed[1] |=> irq_req)
        else $error("armed lock status did not raise request");
    chk_smi_irq: assert property (irq_armed[2] |=> irq_req)
        else $error("armed smi status did not raise request");
    chk_irq_quiet: assert property (irq_armed == 3'h0 |=> !irq_req)
        else $error("request raised with no armed status");

endmodule

/* File: testbench/pmto_top_tb.sv */
// self-checking bench for the pm timeout block: registers, timer, acpi support bits
`timescale 1ns/1ps
`include "pmto_map.svh"

module pmto_top_tb;
    import pmto_pkg::*;
    localparam int MIN_CYC = 16; // short minute keeps each countdown to tens of cycles
    logic        pclk;
    logic        presetn;
    pmto_apb_s   apb_req;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        soft_reset;
    logic        pm_activate;
    logic [2:0]  unit_cfg_clk;
    logic [2:0]  unit_clk_en;
    logic [1:0]  serial_busy;
    logic [3:0]  trigger_irq;
    logic        sleep_en_write;
    logic        glock_release_write;
    logic        smi_cmd_write;
    logic        pm_active;
    logic        expiry_output_n;
    logic        irq_req;
    pmto_bases_s bases;
    pmto_acpi_s  acpi_ctl;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          gl_seen = 0;
    logic [31:0] rdat;
    logic        rerr;

    pmto_top #(.MINUTE_CYCLES(36'(MIN_CYC))) dut_u (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .soft_reset(soft_reset), .pm_activate(pm_activate),
        .unit_cfg_clk(unit_cfg_clk), .unit_clk_en(unit_clk_en), .serial_busy(serial_busy),
        .trigger_irq(trigger_irq), .sleep_en_write(sleep_en_write),
        .glock_release_write(glock_release_write), .smi_cmd_write(smi_cmd_write),
        .pm_active(pm_active), .expiry_output_n(expiry_output_n), .irq_req(irq_req),
        .bases(bases), .acpi_ctl(acpi_ctl)
    );

    // 200 mhz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    // counts lock-set pulses, a one-cycle pulse is easy to miss by sampling
    always @(posedge pclk) begin
        if (acpi_ctl.glock_set === 1'b1) gl_seen <= gl_seen + 1;
    end

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}, pstrb: 4'hf};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdat, exp);
    endtask

    // one-cycle pulse: 4 soft reset, 3 activate, 2 sleep, 1 lock release, 0 smi
    task automatic pulse(input int k);
        @(posedge pclk);
        {soft_reset, pm_activate, sleep_en_write, glock_release_write, smi_cmd_write} <= 5'(1 << k);
        @(posedge pclk);
        {soft_reset, pm_activate, sleep_en_write, glock_release_write, smi_cmd_write} <= 5'h00;
    endtask

    task automatic t_reset;
        rdc(`PMTO_OFF_CEB, 32'h0e);
        rdc(`PMTO_OFF_PERIOD, 32'h00);
        rdc(`PMTO_OFF_TRIG, 32'h00);
        rdc(`PMTO_OFF_TSTAT, 32'h01);
        rdc(`PMTO_OFF_SUPPORT, 32'h00);
        rdc(8'h34, 32'h00);
        chk(rerr, 1'b1);
        @(negedge pclk);
        chk(expiry_output_n, 1'b1);
        chk(unit_clk_en, 3'h7);
        $display("reset test done");
    endtask

    task automatic t_clk;
        @(posedge pclk);
        unit_cfg_clk <= 3'h6;
        serial_busy <= 2'h1;
        repeat (2) @(negedge pclk);
        chk(unit_clk_en, 3'h6);
        wr(`PMTO_OFF_CEB, 8'hff);
        rdc(`PMTO_OFF_CEB, 32'h8f);
        wr(`PMTO_OFF_CEB, 8'h0b);
        serial_busy <= 2'h2;
        rdc(`PMTO_OFF_CEB, 32'h4b);
        @(negedge pclk);
        chk(unit_clk_en, 3'h4);
        chk(acpi_ctl.timer_regs_en, 1'b1);
        wr(`PMTO_OFF_CEB, 8'h0e);
        repeat (2) @(negedge pclk);
        chk(acpi_ctl.timer_regs_en, 1'b0);
        $display("clock enable test done");
    endtask

    // one trigger source at a time, then all sources with none enabled
    task automatic t_timer;
        int n;
        for (int i = 0; i < 5; i++) begin
            wr(`PMTO_OFF_TRIG, (i < 4) ? 8'(1 << i) : 8'h00);
            wr(`PMTO_OFF_PERIOD, 8'h02);
            @(negedge pclk);
            chk(expiry_output_n, 1'b1);
            repeat (17) @(posedge pclk);
            rdc(`PMTO_OFF_PERIOD, 32'h02);
            trigger_irq <= (i < 4) ? 4'(1 << i) : 4'hf;
            @(posedge pclk);
            trigger_irq <= 4'h0;
            n = 0;
            while (expiry_output_n !== 1'b0 && n < 100) begin
                @(negedge pclk);
                n++;
            end
            chk(32'(n >= ((i < 4) ? 27 : 4) && n <= ((i < 4) ? 38 : 16)), 32'h1);
            rdc(`PMTO_OFF_TSTAT, 32'h00);
            chk(expiry_output_n, 1'b0);
        end
        wr(`PMTO_OFF_PERIOD, 8'h00);
        @(negedge pclk);
        chk(expiry_output_n, 1'b1);
        $display("timer test done");
    endtask

    task automatic t_pm;
        wr(`PMTO_OFF_TRIG, 8'hff);
        rdc(`PMTO_OFF_TRIG, 32'h0f);
        wr(`PMTO_OFF_PERIOD, 8'hff);
        rdc(`PMTO_OFF_PERIOD, 32'hff);
        wr(`PMTO_OFF_PERIOD, 8'h01);
        repeat (20) @(negedge pclk);
        chk(expiry_output_n, 1'b0);
        pulse(3);
        rdc(`PMTO_OFF_PERIOD, 32'h00);
        rdc(`PMTO_OFF_TRIG, 32'h00);
        rdc(`PMTO_OFF_TSTAT, 32'h01);
        chk(pm_active, 1'b1);
        wr(`PMTO_OFF_PERIOD, 8'h01);
        pulse(4);
        rdc(`PMTO_OFF_PERIOD, 32'h00);
        chk(pm_active, 1'b0);
        repeat (40) @(negedge pclk);
        chk(expiry_output_n, 1'b1);
        $display("activation test done");
    endtask

    task automatic t_base;
        logic [31:0] ro;
        logic [7:0]  lo;
        ro = 32'h0f010303; // read-only low bits per group: event, timer, control, gp
        for (int g = 0; g < 4; g++) begin
            lo = 8'(`PMTO_OFF_BASE + 8 * g);
            rdc(lo, 32'h00);
            wr(lo, 8'hff);
            wr(lo + 8'h04, 8'(8'h50 + g));
            rdc(lo, {24'h0, ~ro[8*g +: 8]});
            @(negedge pclk);
            chk(bases[63-16*g -: 16], {8'(8'h50 + g), ~ro[8*g +: 8]});
        end
        $display("base address test done");
    endtask

    task automatic t_support;
        int n0;
        pulse(2);
        rdc(`PMTO_OFF_SUPPORT, 32'h01);
        chk(irq_req, 1'b0);
        wr(`PMTO_OFF_SUPPORT, 8'h02);
        repeat (2) @(negedge pclk);
        chk(irq_req, 1'b1);
        wr(`PMTO_OFF_SUPPORT, 8'h03);
        rdc(`PMTO_OFF_SUPPORT, 32'h02);
        chk(irq_req, 1'b0);
        pulse(1);
        rdc(`PMTO_OFF_SUPPORT, 32'h06);
        wr(`PMTO_OFF_SUPPORT, 8'h08);
        repeat (2) @(negedge pclk);
        chk(irq_req, 1'b1);
        wr(`PMTO_OFF_SUPPORT, 8'h0c);
        repeat (2) @(negedge pclk);
        chk(irq_req, 1'b0);
        n0 = gl_seen;
        wr(`PMTO_OFF_SUPPORT, 8'h08);
        wr(`PMTO_OFF_SUPPORT, 8'h18);
        repeat (3) @(negedge pclk);
        chk(32'(gl_seen - n0), 32'h1);
        rdc(`PMTO_OFF_SUPPORT, 32'h08);
        pulse(0);
        wr(`PMTO_OFF_SUPPORT, 8'h40);
        rdc(`PMTO_OFF_SUPPORT, 32'h60);
        chk(irq_req, 1'b1);
        wr(`PMTO_OFF_SUPPORT, 8'ha0);
        rdc(`PMTO_OFF_SUPPORT, 32'h80);
        chk(acpi_ctl.pm1_other_mask, 1'b1);
        chk(irq_req, 1'b0);
        $display("support register test done");
    endtask

    // main sequence: reset held 16 cycles, then each scenario in turn
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        {soft_reset, pm_activate, sleep_en_write, glock_release_write, smi_cmd_write} = 5'h00;
        unit_cfg_clk = 3'h7;
        serial_busy = 2'h0;
        trigger_irq = 4'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_clk();
        t_timer();
        t_pm();
        t_base();
        t_support();
        test_done();
    end
endmodule
